//--- src/cc_attach_detect.sv
`timescale 1ns/100ps
`default_nettype none
`include "cc_detect_defs.svh"
// ************************************************************
// detection and status logic of a type-c configuration channel
// ************************************************************
module cc_attach_detect (
  input wire logic clock, // 250 MHz
  input wire logic rst, // sync, active high
  input wire logic [1:0] roleSel, // 0 disabled, 1 sink, 2 source
  input wire logic measureBus, // route DAC compare to bus voltage
  input wire logic ccSelect, // which CC pin is measured (0 = CC1)
  input wire logic [`DAC_CODE_W-1:0] dacCodeIn, // DAC threshold code
  input wire logic [`CUR_W-1:0] currentSelIn, // source_current_select
  input wire logic currentSelWr, // write strobe for current select
  input wire logic [`IRQ_W-1:0] irqClear, // write-one-to-clear pulses
  input wire logic [`IRQ_W-1:0] irqMask, // 1 masks the flag off the pin
  input wire logic [2:0] cc1Thermo, // fixed comparators on CC1
  input wire logic [2:0] cc2Thermo, // fixed comparators on CC2
  input wire logic ccActivity, // analog activity detector on CC pins
  input wire logic busAbove, // fixed bus-valid comparator
  input wire logic dacCcAbove, // DAC comparator output, CC path
  input wire logic dacBusAbove, // DAC comparator output, bus path (to 15 V)
  output logic [`LEVEL_W-1:0] ccLevelCode, // cc_level_code status
  output logic compResult, // DAC compare status
  output logic busVoltageValid, // bus_voltage_valid status
  output logic [`IRQ_W-1:0] irqFlags, // sticky interrupt flags
  output logic [`DAC_CODE_W-1:0] dacCode, // threshold code to DAC
  output logic measureBusOut, // DAC input mux select
  output logic [1:0] pullDownEn, // Rd enable per CC pin
  output logic [1:0] pullUpEn, // current source enable per CC pin
  output logic [`CUR_W-1:0] pullUpLevel, // advertised current level
  output logic intOut, // open-drain interrupt pin output (always 0)
  output logic intOe // drives pin low while high
);
  // ************************************************************
  // role and termination
  // ************************************************************
  cc_detect_pkg::role_e role_q, role_d;
  logic [`CUR_W-1:0] cur_q, cur_d;
  logic [`DAC_CODE_W-1:0] dac_q, dac_d;
  logic meas_q, meas_d;
  logic sel_q, sel_d;

  always_comb begin
    case (roleSel)
      2'h1: role_d = cc_detect_pkg::ROLE_SINK;
      2'h2: role_d = cc_detect_pkg::ROLE_SOURCE;
      default: role_d = cc_detect_pkg::ROLE_DISABLED;
    endcase
    // a write is applied on the next clock whether or not attached; otherwise the level is held
    cur_d = currentSelWr ? currentSelIn : cur_q;
    dac_d = dacCodeIn;
    meas_d = measureBus;
    sel_d = ccSelect;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      role_q <= cc_detect_pkg::ROLE_DISABLED;
      cur_q <= `CUR_RESET;
      dac_q <= `DAC_RESET;
      meas_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      role_q <= role_d;
      cur_q <= cur_d;
      dac_q <= dac_d;
      meas_q <= meas_d;
      sel_q <= sel_d;
    end
  end

  always_comb begin
    pullDownEn = 2'h0;
    pullUpEn = 2'h0;
    case (role_q)
      cc_detect_pkg::ROLE_SINK: pullDownEn = 2'h3;
      cc_detect_pkg::ROLE_SOURCE: pullUpEn = 2'h3;
      cc_detect_pkg::ROLE_DISABLED: begin
        pullDownEn = 2'h0;
        pullUpEn = 2'h0;
      end
      default: begin
        pullDownEn = 2'h0;
        pullUpEn = 2'h0;
      end
    endcase
  end

  assign pullUpLevel = cur_q;
  assign dacCode = dac_q;
  assign measureBusOut = meas_q;

  // ************************************************************
  // live status
  // ************************************************************
  logic [1:0] level1, level2;
  cc_level_encoder u_enc1 (.thermo(cc1Thermo), .code(level1));
  cc_level_encoder u_enc2 (.thermo(cc2Thermo), .code(level2));

  logic [`LEVEL_W-1:0] lvl_q, lvl_d;
  logic comp_q, comp_d;
  logic bus_q, bus_d;
  logic act_q, act_d;

  always_comb begin
    lvl_d = sel_q ? level2 : level1;
    comp_d = meas_q ? dacBusAbove : dacCcAbove;
    bus_d = busAbove;
    act_d = ccActivity;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lvl_q <= 2'h0;
      comp_q <= 1'b0;
      bus_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      comp_q <= comp_d;
      bus_q <= bus_d;
      act_q <= act_d;
    end
  end

  assign ccLevelCode = lvl_q;
  assign compResult = comp_q;
  assign busVoltageValid = bus_q;

  // ************************************************************
  // sticky interrupt flags
  // ************************************************************
  // first sample after reset is primed so reset itself raises no level, compare or bus-valid event; wake is not gated
  logic primed_q, primed_d;
  logic [`IRQ_W-1:0] flag_q, flag_d, evt;

  always_comb begin
    evt = '0;
    evt[`IRQ_LEVEL_BIT] = primed_q && (lvl_d != lvl_q);
    evt[`IRQ_COMP_BIT] = primed_q && (comp_d != comp_q);
    evt[`IRQ_BUSOK_BIT] = primed_q && (bus_d != bus_q);
    evt[`IRQ_WAKE_BIT] = (role_q == cc_detect_pkg::ROLE_DISABLED) && act_d && !act_q;
    // set beats a clear in the same cycle
    flag_d = (flag_q & ~irqClear) | evt;
    primed_d = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flag_q <= '0;
      primed_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      primed_q <= primed_d;
    end
  end

  assign irqFlags = flag_q;
  assign intOut = 1'b0;
  assign intOe = |(flag_q & ~irqMask);

  // ************************************************************
  // checks
  // ************************************************************
  level_irq_a: assert property (@(posedge clock) disable iff (rst)
    primed_q && (lvl_d != lvl_q) |=> flag_q[`IRQ_LEVEL_BIT])
    else $error("level change did not set flag");
  bus_irq_a: assert property (@(posedge clock) disable iff (rst)
    $past(primed_q) && $changed(bus_q) |-> flag_q[`IRQ_BUSOK_BIT])
    else $error("bus-valid change did not set flag");
  bus_track_a: assert property (@(posedge clock) disable iff (rst)
    busAbove |=> busVoltageValid)
    else $error("bus-valid does not track comparator");
  wake_irq_a: assert property (@(posedge clock) disable iff (rst)
    (role_q == cc_detect_pkg::ROLE_DISABLED) && act_d && !act_q |=> flag_q[`IRQ_WAKE_BIT])
    else $error("wake flag not raised");
  no_term_a: assert property (@(posedge clock) disable iff (rst)
    (role_q == cc_detect_pkg::ROLE_DISABLED) |-> (pullDownEn == 2'h0 && pullUpEn == 2'h0))
    else $error("termination present while disabled");
  cur_apply_a: assert property (@(posedge clock) disable iff (rst)
    currentSelWr |=> pullUpLevel == $past(currentSelIn))
    else $error("current select not applied");
  cur_hold_a: assert property (@(posedge clock) disable iff (rst)
    !currentSelWr |=> $stable(pullUpLevel))
    else $error("current select changed without write");
  flag_sticky_a: assert property (@(posedge clock) disable iff (rst)
    flag_q[0] && !irqClear[0] |=> flag_q[0])
    else $error("level flag lost without clear");
  int_pin_a: assert property (@(posedge clock) disable iff (rst)
    (flag_q[`IRQ_WAKE_BIT] && !irqMask[`IRQ_WAKE_BIT]) |-> intOe)
    else $error("interrupt pin not asserted");
  comp_path_a: assert property (@(posedge clock) disable iff (rst)
    measureBus ##1 meas_q && dacBusAbove |=> compResult)
    else $error("bus measurement not reported");
  level_map_a: assert property (@(posedge clock) disable iff (rst)
    !ccSelect ##1 !sel_q && cc1Thermo == 3'h7 |=> ccLevelCode == 2'h3)
    else $error("level code wrong");

  attach_c: cover property (@(posedge clock) $rose(busVoltageValid));
  wake_c: cover property (@(posedge clock) $rose(flag_q[`IRQ_WAKE_BIT]));
  level_c: cover property (@(posedge clock) ccLevelCode == 2'h3 && !compResult);
  cur_c: cover property (@(posedge clock) currentSelWr && role_q == cc_detect_pkg::ROLE_SOURCE);
endmodule
`default_nettype wire

//--- src/cc_detect_defs.svh
`ifndef CC_DETECT_DEFS_SVH
`define CC_DETECT_DEFS_SVH
`define DAC_CODE_W 6
`define LEVEL_W 2
`define CUR_W 2
`define IRQ_LEVEL_BIT 0
`define IRQ_COMP_BIT 1
`define IRQ_BUSOK_BIT 2
`define IRQ_WAKE_BIT 3
`define IRQ_W 4
`define CUR_RESET 2'h1
`define DAC_RESET 6'h00
`endif

//--- src/cc_detect_pkg.sv
package cc_detect_pkg;
  typedef enum logic [1:0] {ROLE_DISABLED, ROLE_SINK, ROLE_SOURCE} role_e;
  typedef logic [1:0] level_t;
endpackage

//--- src/cc_level_encoder.sv
`timescale 1ns/100ps
`default_nettype none
// thermometer of the three fixed comparators to a 2-bit level code
module cc_level_encoder (
  input wire logic [2:0] thermo, // fixed comparator outputs, low to high threshold
  output logic [1:0] code // level code
);
  always_comb begin
    if (thermo[2]) begin
      code = 2'h3;
    end else if (thermo[1]) begin
      code = 2'h2;
    end else if (thermo[0]) begin
      code = 2'h1;
    end else begin
      code = 2'h0;
    end
  end
endmodule
`default_nettype wire

//--- testbench/cc_partner_model.sv
`timescale 1ns/100ps
`default_nettype none
// attached port: a host advertising hostAdv while we sink, a Ra or Rd load while we source
module cc_partner_model (
  input wire logic [1:0] attach, // 0 none, 1 Ra, 2 Rd or host
  input wire logic [1:0] hostAdv, // level a host partner advertises
  input wire logic [1:0] pullDownEn, // our Rd per pin
  input wire logic [1:0] pullUpEn, // our current source per pin
  input wire logic [1:0] pullUpLevel, // our advertised level
  output logic [2:0] cc1Thermo, // fixed comparators on CC1
  output logic busAbove, // bus valid comparator
  output logic dacCcAbove, // DAC compare on CC
  output logic ccActivity // activity while unterminated
);
  logic [1:0] lvl;
  always_comb begin
    lvl = 2'h0;
    if (attach == 2'h2 && pullDownEn[0]) lvl = hostAdv;
    if (attach == 2'h2 && pullUpEn[0]) lvl = pullUpLevel;
    if (attach == 2'h1 && pullUpEn[0]) lvl = pullUpLevel - 2'h1;
    cc1Thermo = 3'((4'h1 << lvl) - 4'h1);
    busAbove = attach == 2'h2 && pullDownEn[0];
    // an open line floats above any threshold, which reads as detach
    dacCcAbove = attach == 2'h0 && pullUpEn[0];
    ccActivity = attach != 2'h0 && pullDownEn == 2'h0 && pullUpEn == 2'h0;
  end
endmodule
`default_nettype wire

//--- testbench/typec_cc_attach_detection_tb.sv
`timescale 1ns/100ps
`default_nettype none
module typec_cc_attach_detection_tb;
  logic clock = 1'b0, rst = 1'b1, measureBus = 1'b0, currentSelWr = 1'b0, dacBusAbove = 1'b0;
  logic [1:0] roleSel = 2'h0, currentSelIn = 2'h0, attach = 2'h0, hostAdv = 2'h0;
  logic [5:0] dacCodeIn = 6'h00;
  logic [3:0] irqClear = 4'h0, irqMask = 4'h0, irqFlags;
  logic [2:0] cc1Thermo;
  logic [2:0] cc2Thermo = 3'h3;
  logic ccSelect = 1'b0;
  logic intOut;
  logic busAbove, dacCcAbove, ccActivity, compResult, busVoltageValid, measureBusOut, intOe;
  logic [1:0] ccLevelCode, pullDownEn, pullUpEn, pullUpLevel;
  logic [5:0] dacCode;
  int failures = 0, n_checks = 0;
  // ************************************************************
  // rows: advertised level in the upper half, expected code in the lower
  // ************************************************************
  logic [3:0] rows [4] = '{4'h0, 4'h5, 4'hA, 4'hF};
  always #2 clock = ~clock;
  cc_attach_detect u_cc_attach_detect (.clock(clock), .rst(rst), .roleSel(roleSel),
    .measureBus(measureBus), .ccSelect(ccSelect), .dacCodeIn(dacCodeIn),
    .currentSelIn(currentSelIn), .currentSelWr(currentSelWr), .irqClear(irqClear),
    .irqMask(irqMask), .cc1Thermo(cc1Thermo), .cc2Thermo(cc2Thermo), .ccActivity(ccActivity),
    .busAbove(busAbove), .dacCcAbove(dacCcAbove), .dacBusAbove(dacBusAbove),
    .ccLevelCode(ccLevelCode), .compResult(compResult), .busVoltageValid(busVoltageValid),
    .irqFlags(irqFlags), .dacCode(dacCode), .measureBusOut(measureBusOut),
    .pullDownEn(pullDownEn), .pullUpEn(pullUpEn), .pullUpLevel(pullUpLevel),
    .intOut(intOut), .intOe(intOe));
  cc_partner_model u_cc_partner_model (.attach(attach), .hostAdv(hostAdv),
    .pullDownEn(pullDownEn), .pullUpEn(pullUpEn), .pullUpLevel(pullUpLevel),
    .cc1Thermo(cc1Thermo), .busAbove(busAbove), .dacCcAbove(dacCcAbove),
    .ccActivity(ccActivity));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // let the registered outputs settle, then sample away from the edge
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic clearAll();
    @(posedge clock);
    irqClear <= 4'hF;
    @(posedge clock);
    irqClear <= 4'h0;
    step(2);
  endtask
  task automatic writeCur(input logic [1:0] v);
    @(posedge clock);
    currentSelIn <= v;
    currentSelWr <= 1'b1;
    @(posedge clock);
    currentSelWr <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    summarize();
  end
  initial begin
    step(12);
    chk("pullUpLevel", {6'h0, pullUpLevel}, 8'h01);
    chk("intOe", {7'h0, intOe}, 8'h00);
    chk("intOut", {7'h0, intOut}, 8'h00);
    @(posedge clock);
    rst <= 1'b0;
    attach <= 2'h2;
    step(4);
    chk("terminations", {4'h0, pullDownEn, pullUpEn}, 8'h00);
    chk("wake", {7'h0, irqFlags[3]}, 8'h01);
    chk("intOe", {7'h0, intOe}, 8'h01);
    clearAll();
    chk("flags", {4'h0, irqFlags}, 8'h00);
    @(posedge clock);
    roleSel <= 2'h1;
    dacCodeIn <= 6'h30;
    step(4);
    chk("sink Rd", {7'h0, pullDownEn[0]}, 8'h01);
    chk("busok flag", {7'h0, irqFlags[2]}, 8'h01);
    foreach (rows[i]) begin
      @(posedge clock);
      hostAdv <= rows[i][3:2];
      step(3);
      chk("ccLevelCode", {6'h0, ccLevelCode}, {6'h0, rows[i][1:0]});
      chk("busVoltageValid", {7'h0, busVoltageValid}, 8'h01);
    end
    chk("level flag", {7'h0, irqFlags[0]}, 8'h01);
    chk("3A compare", {7'h0, compResult}, 8'h00);
    @(posedge clock);
    ccSelect <= 1'b1;
    step(3);
    chk("cc2 level", {6'h0, ccLevelCode}, 8'h02);
    @(posedge clock);
    ccSelect <= 1'b0;
    step(3);
    clearAll();
    @(posedge clock);
    irqMask <= 4'hF;
    hostAdv <= 2'h1;
    step(3);
    chk("masked flag", {7'h0, irqFlags[0]}, 8'h01);
    chk("masked intOe", {7'h0, intOe}, 8'h00);
    clearAll();
    @(posedge clock);
    irqMask <= 4'h0;
    attach <= 2'h0;
    step(3);
    chk("detach", {7'h0, busVoltageValid}, 8'h00);
    chk("busok flag", {7'h0, irqFlags[2]}, 8'h01);
    @(posedge clock);
    dacCodeIn <= 6'h30;
    measureBus <= 1'b1;
    dacBusAbove <= 1'b1;
    step(3);
    chk("dacCode", {2'h0, dacCode}, 8'h30);
    chk("bus measure", {6'h0, measureBusOut, compResult}, 8'h03);
    chk("comp flag", {7'h0, irqFlags[1]}, 8'h01);
    @(posedge clock);
    measureBus <= 1'b0;
    step(3);
    chk("cc compare", {7'h0, compResult}, 8'h00);
    writeCur(2'h3);
    @(posedge clock);
    roleSel <= 2'h2;
    attach <= 2'h2;
    step(4);
    chk("source pullUp", {6'h0, pullUpEn[0], pullDownEn[0]}, 8'h02);
    chk("advertised", {4'h0, pullUpLevel, ccLevelCode}, 8'h0F);
    chk("Rd attach", {7'h0, compResult}, 8'h00);
    writeCur(2'h2);
    step(2);
    chk("switched", {4'h0, pullUpLevel, ccLevelCode}, 8'h0A);
    @(posedge clock);
    attach <= 2'h0;
    step(3);
    chk("Rd detach", {7'h0, compResult}, 8'h01);
    summarize();
  end
endmodule
`default_nettype wire
